// [core/uip_regs.svh]
/*
  offsets, field positions, reset values, identification codes and timing counts of the interrupt
  prioritizer; assumes a 3-bit register address and 8-bit register data
*/
`ifndef UIP_REGS_SVH
`define UIP_REGS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define UIP_OFF_RX_BUFFER 3'h0
`define UIP_OFF_TX_HOLDING 3'h0
`define UIP_OFF_INT_ENABLE 3'h1
`define UIP_OFF_INT_ID 3'h2
`define UIP_OFF_LINE_STATUS 3'h5
`define UIP_OFF_MODEM_STATUS 3'h6

// ****************************************************************
// enable register fields
// ****************************************************************
`define UIP_IEN_RX_DATA 0
`define UIP_IEN_TX_EMPTY 1
`define UIP_IEN_LINE 2
`define UIP_IEN_MODEM 3
`define UIP_IEN_XOFF 5
`define UIP_IEN_RTS 6
`define UIP_IEN_CTS 7
`define UIP_IEN_RST 8'h00

// ****************************************************************
// identification codes, bits 5:0
// ****************************************************************
`define UIP_ID_LINE 6'h06
`define UIP_ID_TIMEOUT 6'h0c
`define UIP_ID_RX_DATA 6'h04
`define UIP_ID_TX_EMPTY 6'h02
`define UIP_ID_MODEM 6'h00
`define UIP_ID_XOFF 6'h10
`define UIP_ID_FLOW 6'h20
`define UIP_ID_NONE 6'h01

// ****************************************************************
// receive timeout: words and extra bit times
// ****************************************************************
`define UIP_TO_WORDS 4
`define UIP_TO_EXTRA_BITS 12

`endif

// [core/uip_pkg.sv]
/*
  types of the interrupt prioritizer; assumes uip_regs.svh for all numbers
*/
package uip_pkg;

  // state of the pin synchroniser
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic stable;
  } uip_sync_t;

  // state of the channel prioritizer
  typedef struct packed {
    logic [7:0] ien;
    logic line_pend;
    logic to_pend;
    logic tx_pend;
    logic modem_pend;
    logic xoff_pend;
    logic xoff_special;
    logic cts_pend;
    logic rts_pend;
    logic [7:0] to_cnt;
    logic [3:0] line_prev;
    logic [3:0] modem_prev;
    logic tx_prev;
    logic rts_prev;
    logic [7:0] rdata;
    logic irq;
  } uip_state_t;

endpackage : uip_pkg

// [core/uip_pin_sync.sv]
/*
  three-stage synchroniser with agreement filter and rising-edge pulse for one pin;
  assumes the pin is asynchronous to core_clk_in
*/
`timescale 1ns/100ps

module uip_pin_sync (
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic pin_in,
  output logic rise_out
);

  uip_pkg::uip_sync_t s_q;
  uip_pkg::uip_sync_t s_d;

  // ****************************************************************
  // next state
  // ****************************************************************
  // shift chain; stable level follows once stages two and three agree
  always_comb begin
    s_d = s_q;
    s_d.s1 = pin_in;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    if (s_q.s2 == s_q.s3) begin
      s_d.stable = s_q.s3;
    end
    rise_out = s_q.s2 & s_q.s3 & ~s_q.stable; // one-cycle pulse
  end

  // register, frozen while ce_in is low
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      s_q <= '0;
    end else if (ce_in) begin
      s_q <= s_d;
    end
  end

endmodule : uip_pin_sync

// [core/uip_top.sv]
/*
  one channel's interrupt prioritizer: pending flags, masking, priority encoding of the
  identification register and host-side clearing; assumes the line, modem, fifo and flow logic
  deliver their status on the same clock, cts as a raw pin
*/
// Local design decision: the strobed register port.
// Notes on behaviour
// - seven ranked levels in identification register
// - host read shows frozen highest pending condition
// - new conditions latch while read value holds
// - bits 7:6 mirror fifo enable
// - bit 5 flags cts or rts rise
// - bit 4 flags xoff or special match
// - bit 0 high when nothing pending
// - level 1 line status errors, code 000110
// - level 2 receive timeout, code 001100
// - timeout after four words plus twelve bits
// - level 3 receive trigger reached, code 000100
// - trigger pending until count below level
// - level 4 transmit empty, code 000010
// - transmit empty cleared by id read or write
// - level 5 modem change, code 000000
// - level 6 xoff or special, code 010000
// - xoff cleared by id read, xon, next
// - level 7 cts or rts rise, code 100000
// - cts rise counts only under auto cts
// - rts rise counts only under auto rts
// - line status read clears line interrupt
// - disabled sources hidden but keep tracking
// - upper enables need enhanced mode set
`timescale 1ns/100ps
`include "uip_regs.svh"

module uip_top (
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic [2:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  output logic irq_out,
  input wire logic fifo_enabled_status_in,
  input wire logic enhanced_mode_in,
  input wire logic [7:0] line_status_in,
  input wire logic [7:0] modem_status_in,
  input wire logic [7:0] rx_data_in,
  input wire logic [6:0] rx_count_in,
  input wire logic [6:0] rx_trigger_in,
  input wire logic rx_char_in,
  input wire logic bit_tick_in,
  input wire logic [3:0] char_bits_in,
  input wire logic tx_empty_in,
  input wire logic xoff_match_in,
  input wire logic special_match_in,
  input wire logic xon_match_in,
  input wire logic cts_pin_in,
  input wire logic auto_cts_in,
  input wire logic rts_level_in,
  input wire logic auto_rts_in
);

  uip_pkg::uip_state_t s_q;
  uip_pkg::uip_state_t s_d;
  logic cts_rise;
  logic rx_trig;
  logic [5:0] id_now;
  logic [7:0] to_limit;
  logic rd_id;
  logic rd_line;
  logic rd_modem;
  logic rd_rx;
  logic wr_tx;

  // ****************************************************************
  // priority encoder
  // ****************************************************************
  // highest enabled pending source wins; disabled sources never show
  function automatic logic [5:0] uip_encode(input uip_pkg::uip_state_t s, input logic trig, input logic enh);
    logic [5:0] code;
    code = `UIP_ID_NONE;
    if (s.ien[`UIP_IEN_LINE] && s.line_pend) begin
      code = `UIP_ID_LINE;
    end else if (s.ien[`UIP_IEN_RX_DATA] && s.to_pend) begin
      code = `UIP_ID_TIMEOUT;
    end else if (s.ien[`UIP_IEN_RX_DATA] && trig) begin
      code = `UIP_ID_RX_DATA;
    end else if (s.ien[`UIP_IEN_TX_EMPTY] && s.tx_pend) begin
      code = `UIP_ID_TX_EMPTY;
    end else if (s.ien[`UIP_IEN_MODEM] && s.modem_pend) begin
      code = `UIP_ID_MODEM;
    end else if (enh && s.ien[`UIP_IEN_XOFF] && s.xoff_pend) begin
      code = `UIP_ID_XOFF;
    end else if (enh && ((s.ien[`UIP_IEN_CTS] && s.cts_pend) || (s.ien[`UIP_IEN_RTS] && s.rts_pend))) begin
      code = `UIP_ID_FLOW;
    end
    return code;
  endfunction : uip_encode

  // ****************************************************************
  // cts pin synchroniser
  // ****************************************************************
  uip_pin_sync u_cts_sync (
    .core_clk_in(core_clk_in),
    .srst_in(srst_in),
    .ce_in(ce_in),
    .pin_in(cts_pin_in),
    .rise_out(cts_rise)
  );

  // ****************************************************************
  // decode and level conditions
  // ****************************************************************
  // host access strobes and the receive trigger level
  assign rd_id = rd_in && (addr_in == `UIP_OFF_INT_ID);
  assign rd_line = rd_in && (addr_in == `UIP_OFF_LINE_STATUS);
  assign rd_modem = rd_in && (addr_in == `UIP_OFF_MODEM_STATUS);
  assign rd_rx = rd_in && (addr_in == `UIP_OFF_RX_BUFFER);
  assign wr_tx = wr_in && (addr_in == `UIP_OFF_TX_HOLDING);
  assign rx_trig = (rx_count_in != 7'h00) && (rx_count_in >= rx_trigger_in);
  assign id_now = uip_encode(s_q, rx_trig, enhanced_mode_in);
  assign to_limit = 8'(char_bits_in * `UIP_TO_WORDS) + 8'(`UIP_TO_EXTRA_BITS);

  // ****************************************************************
  // next state
  // ****************************************************************
  // clears first, sets after, so an event in the clearing cycle survives
  always_comb begin
    s_d = s_q;
    s_d.rdata = 8'h00;
    // read data, captured once per access so the shown value cannot move
    if (rd_in) begin
      case (addr_in)
        `UIP_OFF_RX_BUFFER: begin
          s_d.rdata = rx_data_in;
        end
        `UIP_OFF_INT_ENABLE: begin
          s_d.rdata = s_q.ien;
        end
        `UIP_OFF_INT_ID: begin
          s_d.rdata = {fifo_enabled_status_in, fifo_enabled_status_in, id_now};
        end
        `UIP_OFF_LINE_STATUS: begin
          s_d.rdata = line_status_in;
        end
        `UIP_OFF_MODEM_STATUS: begin
          s_d.rdata = modem_status_in;
        end
        default: begin
          s_d.rdata = 8'h00;
        end
      endcase
    end
    // enable register write
    if (wr_in && (addr_in == `UIP_OFF_INT_ENABLE)) begin
      s_d.ien = wdata_in;
    end
    // line status: cleared by its read, error flags themselves stay outside
    if (rd_line) begin
      s_d.line_pend = 1'b0;
    end
    if ((line_status_in[4:1] & ~s_q.line_prev) != 4'h0) begin
      s_d.line_pend = 1'b1;
    end
    s_d.line_prev = line_status_in[4:1];
    // receive timeout counter in bit times, restarted by any receiver activity
    if (rd_rx || rx_char_in || (rx_count_in == 7'h00) || !fifo_enabled_status_in) begin
      s_d.to_cnt = 8'h00;
    end else if (bit_tick_in && (s_q.to_cnt != to_limit)) begin
      s_d.to_cnt = s_q.to_cnt + 8'h01;
      if (s_d.to_cnt == to_limit) begin
        s_d.to_pend = 1'b1;
      end
    end
    if (rd_rx) begin
      s_d.to_pend = 1'b0;
    end
    // transmit empty
    if (wr_tx || (rd_id && (id_now == `UIP_ID_TX_EMPTY))) begin
      s_d.tx_pend = 1'b0;
    end
    if (tx_empty_in && !s_q.tx_prev) begin
      s_d.tx_pend = 1'b1;
    end
    s_d.tx_prev = tx_empty_in;
    // modem status change
    if (rd_modem) begin
      s_d.modem_pend = 1'b0;
    end
    if ((modem_status_in[3:0] & ~s_q.modem_prev) != 4'h0) begin
      s_d.modem_pend = 1'b1;
    end
    s_d.modem_prev = modem_status_in[3:0];
    // xoff or special character
    if ((rd_id && (id_now == `UIP_ID_XOFF)) || xon_match_in || (s_q.xoff_special && rx_char_in)) begin
      s_d.xoff_pend = 1'b0;
    end
    if (xoff_match_in || special_match_in) begin
      s_d.xoff_pend = 1'b1;
      s_d.xoff_special = special_match_in && !xoff_match_in;
    end
    // cts and rts rising edges under automatic flow control
    if ((rd_id && (id_now == `UIP_ID_FLOW)) || rd_modem) begin
      s_d.cts_pend = 1'b0;
      s_d.rts_pend = 1'b0;
    end
    if (cts_rise && auto_cts_in) begin
      s_d.cts_pend = 1'b1;
    end
    if (rts_level_in && !s_q.rts_prev && auto_rts_in) begin
      s_d.rts_pend = 1'b1;
    end
    s_d.rts_prev = rts_level_in;
    // interrupt line follows the pending set
    s_d.irq = uip_encode(s_d, rx_trig, enhanced_mode_in) != `UIP_ID_NONE;
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  // reset clears all pending flags; ce_in low freezes everything
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      s_q <= '0;
      s_q.ien <= `UIP_IEN_RST;
    end else if (ce_in) begin
      s_q <= s_d;
    end
  end

  // outputs straight from flops
  assign rdata_out = s_q.rdata;
  assign irq_out = s_q.irq;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (srst_in || !ce_in);

  // host reads of the identification register
  sequence id_read_s;
    rd_in && (addr_in == `UIP_OFF_INT_ID);
  endsequence

  sequence line_first_s;
    id_read_s ##0 (s_q.ien[`UIP_IEN_LINE] && s_q.line_pend);
  endsequence

  sequence timeout_second_s;
    id_read_s ##0 (!(s_q.ien[`UIP_IEN_LINE] && s_q.line_pend) && s_q.ien[`UIP_IEN_RX_DATA] && s_q.to_pend);
  endsequence

  a_idle_bit_irq: assert property (id_read_s |=> rdata_out[0] == !$past(irq_out))
    else $error("bit 0 disagrees with interrupt line");

  a_line_top_code: assert property (line_first_s |=> rdata_out[5:0] == 6'h06)
    else $error("line status not shown first");

  a_timeout_code: assert property (timeout_second_s |=> rdata_out[5:0] == 6'h0c)
    else $error("timeout code wrong");

  a_fifo_mirror: assert property (id_read_s |=> rdata_out[7:6] == {2{$past(fifo_enabled_status_in)}})
    else $error("fifo enable bits wrong");

  a_read_once: assert property (id_read_s ##1 !rd_in |=> rdata_out == 8'h00)
    else $error("read data outlived its cycle");

  a_tx_clear_write: assert property ((wr_tx && !(tx_empty_in && !s_q.tx_prev)) |=> !s_q.tx_pend)
    else $error("transmit empty not cleared by write");

  a_modem_clear: assert property ((rd_modem && ((modem_status_in[3:0] & ~s_q.modem_prev) == 4'h0)) |=> !s_q.modem_pend)
    else $error("modem pending survived its read");

  a_line_clear: assert property ((rd_line && ((line_status_in[4:1] & ~s_q.line_prev) == 4'h0)) |=> !s_q.line_pend)
    else $error("line pending survived its read");

  a_cts_gated: assert property ($rose(s_q.cts_pend) |-> $past(auto_cts_in))
    else $error("cts pending without auto cts");

  a_rts_gated: assert property ($rose(s_q.rts_pend) |-> $past(auto_rts_in) && $past(rts_level_in))
    else $error("rts pending without auto rts rise");

  a_set_wins: assert property ((wr_tx && tx_empty_in && !s_q.tx_prev) |=> s_q.tx_pend)
    else $error("transmit empty event lost");

  a_xon_clears: assert property ((xon_match_in && !xoff_match_in && !special_match_in) |=> !s_q.xoff_pend)
    else $error("xon did not clear xoff pending");

  a_hidden_masked: assert property ((s_q.ien == 8'h00) |-> !irq_out)
    else $error("masked source raised interrupt");

  // ****************************************************************
  // pending flag checks
  // ****************************************************************
  // receive trigger shown when nothing of higher rank is enabled and pending
  sequence trig_third_s;
    id_read_s ##0 (s_q.ien[`UIP_IEN_RX_DATA] && (rx_count_in != 7'h00) && (rx_count_in >= rx_trigger_in)
      && !(s_q.ien[`UIP_IEN_LINE] && s_q.line_pend) && !s_q.to_pend);
  endsequence

  // modem read with no fresh flow control rise in the same cycle
  sequence modem_read_quiet_s;
    rd_modem ##0 (!(cts_rise && auto_cts_in) && !(rts_level_in && !s_q.rts_prev && auto_rts_in));
  endsequence

  a_trig_code: assert property (trig_third_s |=> rdata_out[5:0] == `UIP_ID_RX_DATA)
    else $error("receive trigger code wrong");

  a_upper_gated: assert property ((id_read_s ##0 !enhanced_mode_in) |=> rdata_out[5:4] == 2'b00)
    else $error("upper source shown without enhanced mode");

  a_reset_quiet: assert property ($fell(srst_in) |-> !irq_out && (rdata_out == 8'h00))
    else $error("state not cleared by reset");

  // set events
  a_line_set: assert property (((line_status_in[4:1] & ~s_q.line_prev) != 4'h0) |=> s_q.line_pend)
    else $error("line error rise not latched");

  a_modem_set: assert property (((modem_status_in[3:0] & ~s_q.modem_prev) != 4'h0) |=> s_q.modem_pend)
    else $error("modem change not latched");

  a_tx_set: assert property ((tx_empty_in && !s_q.tx_prev) |=> s_q.tx_pend)
    else $error("transmit empty rise not latched");

  a_xoff_set: assert property ((xoff_match_in || special_match_in) |=> s_q.xoff_pend)
    else $error("xoff or special match not latched");

  // clear actions
  a_tx_clear_read: assert property ((id_read_s ##0 ((id_now == `UIP_ID_TX_EMPTY) && !(tx_empty_in && !s_q.tx_prev)))
    |=> !s_q.tx_pend)
    else $error("transmit empty not cleared by id read");

  a_special_next: assert property ((s_q.xoff_pend && s_q.xoff_special && rx_char_in && !xoff_match_in
    && !special_match_in) |=> !s_q.xoff_pend)
    else $error("special match not cleared by next character");

  a_flow_clear_modem: assert property (modem_read_quiet_s |=> !s_q.cts_pend && !s_q.rts_pend)
    else $error("flow pending survived modem read");

  a_to_read_clears: assert property (rd_rx |=> !s_q.to_pend)
    else $error("timeout survived receive read");

endmodule : uip_top

// [sim/uip_host_model.sv]
/*
  host cpu model: single-cycle register writes and reads of one channel;
  assumes the shared core clock and read data in the cycle after the strobe
*/
`timescale 1ns/100ps

module uip_host_model (
  input wire logic core_clk_in,
  input wire logic [7:0] rdata_in,
  output logic [2:0] addr_out,
  output logic [7:0] wdata_out,
  output logic wr_out,
  output logic rd_out
);
  // ****************************************************************
  // bus cycles
  // ****************************************************************
  // idle bus at time zero
  initial begin
    addr_out = 3'h0;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end

  // one-cycle write, data inverted once released so stale values never pass
  task bus_write(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge core_clk_in);
    wr_out <= 1'b0;
    wdata_out <= ~d;
  endtask : bus_write

  // one-cycle read, data taken at the edge that closes the following cycle
  task bus_read(input logic [2:0] a, output logic [7:0] d);
    @(posedge core_clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge core_clk_in);
    rd_out <= 1'b0;
    @(posedge core_clk_in);
    d = rdata_in; // still the value launched one edge earlier
  endtask : bus_read
endmodule : uip_host_model

// [sim/uip_top_bench.sv]
/*
  self-checking bench of the channel prioritizer; drives status inputs directly
  and reaches the registers through the host model; assumes 100 ns clock
*/
`timescale 1ns/100ps

module uip_top_bench;
  logic clk = 1'b0, srst = 1'b1, fifo = 1'b0, enh = 1'b0, tick = 1'b0, rxc = 1'b0, ce = 1'b1;
  logic [7:0] line_status_reg = 8'h00, modem_status_reg = 8'h00, rdata;
  logic [6:0] cnt = 7'h00, trg = 7'h04;
  logic txe = 1'b0, xoff = 1'b0, spc = 1'b0, xon = 1'b0, cts = 1'b0, acts = 1'b0, rts = 1'b0, arts = 1'b0;
  logic [2:0] addr;
  logic [7:0] wdata, v;
  logic wr, rd, irq;
  int error_cnt = 0, n_tests = 0;

  // ****************************************************************
  // clock, instances
  // ****************************************************************
  // 10 MHz clock
  initial begin
    forever #50 clk = ~clk;
  end

  uip_top uip_top_i (.core_clk_in(clk), .srst_in(srst), .ce_in(ce), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .irq_out(irq), .fifo_enabled_status_in(fifo),
    .enhanced_mode_in(enh), .line_status_in(line_status_reg), .modem_status_in(modem_status_reg), .rx_data_in(8'ha5),
    .rx_count_in(cnt), .rx_trigger_in(trg), .rx_char_in(rxc), .bit_tick_in(tick), .char_bits_in(4'ha),
    .tx_empty_in(txe), .xoff_match_in(xoff), .special_match_in(spc), .xon_match_in(xon),
    .cts_pin_in(cts), .auto_cts_in(acts), .rts_level_in(rts), .auto_rts_in(arts));

  uip_host_model uip_host_model_i (.core_clk_in(clk), .rdata_in(rdata), .addr_out(addr),
    .wdata_out(wdata), .wr_out(wr), .rd_out(rd));

  // ****************************************************************
  // helpers
  // ****************************************************************
  // compare and count
  task check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // read a register and compare
  task rd_is(input logic [2:0] a, input logic [7:0] exp);
    uip_host_model_i.bus_read(a, v);
    check(v, exp);
  endtask : rd_is

  task wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_clk

  // verdict and end of run
  task stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  // hang guard
  initial begin
    #5000000;
    error_cnt++;
    stop_test;
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    wait_clk(8);
    srst <= 1'b0;
    rd_is(3'h2, 8'h01);
    rd_is(3'h1, 8'h00);
    rd_is(3'h3, 8'h00);
    // tx empty raised, cleared by id read and by holding write
    uip_host_model_i.bus_write(3'h1, 8'h0e);
    rd_is(3'h1, 8'h0e);
    txe <= 1'b1;
    wait_clk(2);
    check({7'h00, irq}, 8'h01);
    rd_is(3'h2, 8'h02);
    rd_is(3'h2, 8'h01);
    check({7'h00, irq}, 8'h00);
    txe <= 1'b0;
    wait_clk(1);
    txe <= 1'b1;
    uip_host_model_i.bus_write(3'h0, 8'h55);
    rd_is(3'h2, 8'h01);
    // four of the five lower sources at once (all but timeout), served in rank order
    fifo <= 1'b1;
    txe <= 1'b0;
    uip_host_model_i.bus_write(3'h1, 8'h0f);
    txe <= 1'b1;
    modem_status_reg <= 8'h01;
    line_status_reg <= 8'h02;
    cnt <= 7'h04;
    wait_clk(2);
    rd_is(3'h2, 8'hc6);
    rd_is(3'h5, 8'h02);
    rd_is(3'h2, 8'hc4);
    cnt <= 7'h03;
    rd_is(3'h2, 8'hc2);
    rd_is(3'h2, 8'hc0);
    rd_is(3'h6, 8'h01);
    rd_is(3'h2, 8'hc1);
    // masked source keeps tracking
    txe <= 1'b0;
    uip_host_model_i.bus_write(3'h1, 8'h00);
    txe <= 1'b1;
    wait_clk(2);
    rd_is(3'h2, 8'hc1);
    check({7'h00, irq}, 8'h00);
    uip_host_model_i.bus_write(3'h1, 8'h02);
    wait_clk(2);
    rd_is(3'h2, 8'hc2);
    // upper enables need enhanced mode
    uip_host_model_i.bus_write(3'h1, 8'he0);
    xoff <= 1'b1;
    wait_clk(1);
    xoff <= 1'b0;
    rd_is(3'h2, 8'hc1);
    enh <= 1'b1;
    wait_clk(2);
    rd_is(3'h2, 8'hd0);
    rd_is(3'h2, 8'hc1);
    xoff <= 1'b1;
    wait_clk(1);
    xoff <= 1'b0;
    xon <= 1'b1;
    wait_clk(1);
    xon <= 1'b0;
    rd_is(3'h2, 8'hc1);
    spc <= 1'b1;
    wait_clk(1);
    spc <= 1'b0;
    rxc <= 1'b1;
    wait_clk(1);
    rxc <= 1'b0;
    rd_is(3'h2, 8'hc1);
    // flow control rises
    cts <= 1'b1;
    wait_clk(8);
    rd_is(3'h2, 8'hc1);
    cts <= 1'b0;
    acts <= 1'b1;
    wait_clk(8);
    cts <= 1'b1;
    wait_clk(8);
    rd_is(3'h2, 8'he0);
    rd_is(3'h2, 8'hc1);
    arts <= 1'b1;
    rts <= 1'b1;
    xoff <= 1'b1;
    wait_clk(1);
    xoff <= 1'b0;
    wait_clk(2);
    rd_is(3'h2, 8'hd0);
    check({7'h00, irq}, 8'h01);
    rd_is(3'h6, 8'h01);
    rd_is(3'h2, 8'hc1);
    // receive timeout after four words of ten bits plus twelve
    uip_host_model_i.bus_write(3'h1, 8'h01);
    cnt <= 7'h01;
    tick <= 1'b1;
    wait_clk(50);
    rd_is(3'h2, 8'hc1);
    rd_is(3'h2, 8'hcc);
    tick <= 1'b0;
    rd_is(3'h0, 8'ha5);
    rd_is(3'h2, 8'hc1);
    // clock enable low: the enable write is not taken
    ce <= 1'b0;
    uip_host_model_i.bus_write(3'h1, 8'hff);
    ce <= 1'b1;
    rd_is(3'h1, 8'h01);
    stop_test;
  end
endmodule : uip_top_bench
